// [logic/drs_params.svh]
// Offsets, bit positions and reset values of the loop and reference status group
`ifndef DRS_PARAMS_SVH
`define DRS_PARAMS_SVH

// Byte addresses on the control port
`define DRS_ADDR_IO_UPDATE 16'h0005
`define DRS_ADDR_REF_EVENT 16'h0D06
`define DRS_ADDR_RSVD_EVENT 16'h0D07
`define DRS_ADDR_LOOP_STATE 16'h0D08
`define DRS_ADDR_LOOP_REF 16'h0D09
`define DRS_ADDR_RSVD_A 16'h0D0A
`define DRS_ADDR_INPUT_REF 16'h0D0B
`define DRS_ADDR_RSVD_B 16'h0D0C
`define DRS_ADDR_TUNE_B0 16'h0D0D
`define DRS_ADDR_TUNE_B1 16'h0D0E
`define DRS_ADDR_TUNE_B2 16'h0D0F
`define DRS_ADDR_TUNE_B3 16'h0D10
`define DRS_ADDR_PHASE_LO 16'h0D11
`define DRS_ADDR_PHASE_HI 16'h0D12
`define DRS_ADDR_FREQ_LO 16'h0D13
`define DRS_ADDR_FREQ_HI 16'h0D14

// Value that triggers a status refresh
`define DRS_IO_UPDATE_VAL 8'h01

// Reference event register bit positions
`define DRS_EV_A_FAULT 0
`define DRS_EV_A_CLEARED 1
`define DRS_EV_A_VALIDATED 2
`define DRS_EV_B_FAULT 4
`define DRS_EV_B_CLEARED 5
`define DRS_EV_B_VALIDATED 6

// Input reference status: second reference field starts here
`define DRS_REF_B_SHIFT 4

// Reset values
`define DRS_EVENT_RESET 8'h00
`define DRS_SNAP_RESET 8'h00
`define DRS_READ_RESET 8'h00

`endif

// [logic/drs_pkg.sv]
// Types of the loop and reference status group
package drs_pkg;

    // Raw condition of one reference from its monitor
    typedef struct packed {
        logic timer_expired;
        logic fault;
        logic fast;
        logic slow;
        logic missing;
    } drs_ref_in_t;

    // Live state of the digital loop
    typedef struct packed {
        logic slew_limited;
        logic freq_lock;
        logic phase_lock;
        logic switching;
        logic holdover;
        logic active;
        logic freerun;
    } drs_loop_t;

    // Everything the monitored logic reports
    typedef struct packed {
        drs_ref_in_t second_reference;
        drs_ref_in_t first_reference;
        drs_loop_t loop;
        logic clamped;
        logic history_ready;
        logic [1:0] active_priority;
        logic active_index;
        logic [29:0] tuning_word;
        logic [11:0] phase_level;
        logic [11:0] freq_level;
    } drs_live_t;

    // Control port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } drs_bus_t;

    // All state of the status block
    typedef struct packed {
        logic [7:0] events;
        logic [1:0] prev_valid;
        logic [1:0] prev_fault;
        logic [7:0] ref_snap;
        logic [7:0] rd_data;
    } drs_state_t;

endpackage

// [logic/drs_readback.sv]
// Loop and reference status readback with sticky reference event monitor
//
// Notes on behaviour
// - Validated events at bits 6 and 2.
// - Fault-cleared events at bits 5 and 1.
// - Fault events at bits 4 and 0.
// - Loop state bits: free run, active, holdover.
// - Switchover bit 3 high while switching.
// - Phase lock bit 4, frequency lock bit 5.
// - Bit 6 set while offset rate limited.
// - Clamp flag at bit 5, second register.
// - History available flag at bit 4.
// - Active reference priority in bits 3 to 2.
// - Active reference index at bit 0.
// - Valid only when unfaulted and timer expired.
// - Fault flag whenever reference unusable.
// - Fast flag above upper frequency limit.
// - Slow flag below lower frequency limit.
// - Missing clock sets fast and slow together.
// - Tuning word over four bytes, LSB first.
// - Phase lock level, 12 bits, read-only.
// - Frequency lock level, 12 bits, read-only.
// - Event bit set only when not masked.
// - Event bits sticky until cleared or reset.
`timescale 1ns/1ps
`include "drs_params.svh"

module drs_readback (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Control port
    input wire drs_pkg::drs_bus_t bus,
    output logic [7:0] rd_data,
    // Monitored loop and references
    input wire drs_pkg::drs_live_t live,
    // Event mask and clearing controls
    input wire logic [7:0] ev_mask,
    input wire logic [7:0] ev_clear,
    input wire logic ev_clear_all
);

    drs_pkg::drs_state_t st;
    drs_pkg::drs_state_t next_st;
    logic [3:0] eff_a;
    logic [3:0] eff_b;
    logic [7:0] ev_set;
    logic io_update;

    // Effective {valid, fault, fast, slow} of one reference
    function automatic logic [3:0] ref_effective(input drs_pkg::drs_ref_in_t r);
        logic flt;
        flt = r.fault | r.missing;
        ref_effective = {r.timer_expired & ~flt,
                         flt,
                         r.fast | r.missing,
                         r.slow | r.missing};
    endfunction

    // Read decode; unmapped and reserved locations answer zero
    function automatic logic [7:0] read_mux(input logic [15:0] a,
                                            input drs_pkg::drs_state_t s,
                                            input drs_pkg::drs_live_t l);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            `DRS_ADDR_REF_EVENT: d = s.events & 8'h77;
            `DRS_ADDR_LOOP_STATE: d = {1'b0, l.loop};
            `DRS_ADDR_LOOP_REF: d = {2'b00, l.clamped, l.history_ready,
                                     l.active_priority, 1'b0, l.active_index};
            `DRS_ADDR_INPUT_REF: d = s.ref_snap;
            `DRS_ADDR_TUNE_B0: d = l.tuning_word[7:0];
            `DRS_ADDR_TUNE_B1: d = l.tuning_word[15:8];
            `DRS_ADDR_TUNE_B2: d = l.tuning_word[23:16];
            `DRS_ADDR_TUNE_B3: d = {2'b00, l.tuning_word[29:24]};
            `DRS_ADDR_PHASE_LO: d = l.phase_level[7:0];
            `DRS_ADDR_PHASE_HI: d = {4'h0, l.phase_level[11:8]};
            `DRS_ADDR_FREQ_LO: d = l.freq_level[7:0];
            `DRS_ADDR_FREQ_HI: d = {4'h0, l.freq_level[11:8]};
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    always_comb
    begin
        eff_a = ref_effective(live.first_reference);
        eff_b = ref_effective(live.second_reference);
        // Edges taken against the last cycle so a single-cycle glitch still logs
        ev_set = 8'h00;
        ev_set[`DRS_EV_A_VALIDATED] = eff_a[3] & ~st.prev_valid[0];
        ev_set[`DRS_EV_A_CLEARED] = ~eff_a[2] & st.prev_fault[0];
        ev_set[`DRS_EV_A_FAULT] = eff_a[2] & ~st.prev_fault[0];
        ev_set[`DRS_EV_B_VALIDATED] = eff_b[3] & ~st.prev_valid[1];
        ev_set[`DRS_EV_B_CLEARED] = ~eff_b[2] & st.prev_fault[1];
        ev_set[`DRS_EV_B_FAULT] = eff_b[2] & ~st.prev_fault[1];
        ev_set = ev_set & ~ev_mask;
        io_update = bus.wr && bus.addr == `DRS_ADDR_IO_UPDATE
                    && bus.wdata == `DRS_IO_UPDATE_VAL;
        next_st = st;
        next_st.prev_valid = {eff_b[3], eff_a[3]};
        next_st.prev_fault = {eff_b[2], eff_a[2]};
        // A new event beats a clear in the same cycle
        next_st.events = ((st.events & ~ev_clear & {8{~ev_clear_all}}) | ev_set)
                         & 8'h77;
        // Snapshot keeps software reads coherent across the whole byte
        if (io_update)
        begin
            next_st.ref_snap = {eff_b, eff_a};
        end
        next_st.rd_data = bus.rd ? read_mux(bus.addr, st, live) : 8'h00;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st.events <= `DRS_EVENT_RESET;
            st.prev_valid <= 2'h0;
            st.prev_fault <= 2'h0;
            st.ref_snap <= `DRS_SNAP_RESET;
            st.rd_data <= `DRS_READ_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;

    chk_first_validated: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (eff_a[3] && !st.prev_valid[0] && !ev_mask[`DRS_EV_A_VALIDATED])
        |=> st.events[`DRS_EV_A_VALIDATED])
        else $error("first reference validated event lost");

    chk_second_fault_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (eff_b[2] && !st.prev_fault[1] && !ev_mask[`DRS_EV_B_FAULT])
        |=> st.events[`DRS_EV_B_FAULT])
        else $error("second reference fault event lost");

    chk_fault_cleared: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!eff_a[2] && st.prev_fault[0] && !ev_mask[`DRS_EV_A_CLEARED])
        |=> st.events[`DRS_EV_A_CLEARED])
        else $error("first reference fault cleared event lost");

    chk_mask_blocks: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!st.events[`DRS_EV_B_FAULT] && ev_mask[`DRS_EV_B_FAULT])
        |=> !st.events[`DRS_EV_B_FAULT])
        else $error("masked event was recorded");

    chk_event_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st.events[`DRS_EV_A_FAULT] && !ev_clear[`DRS_EV_A_FAULT] && !ev_clear_all)
        |=> st.events[`DRS_EV_A_FAULT])
        else $error("event bit dropped without a clear");

    chk_clear_all: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ev_clear_all && ev_set == 8'h00) |=> st.events == 8'h00)
        else $error("clear all left an event set");

    chk_snap_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !io_update |=> $stable(st.ref_snap))
        else $error("reference status changed without update");

    chk_missing_clock: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (io_update && live.first_reference.missing)
        |=> st.ref_snap[1:0] == 2'b11 && st.ref_snap[2] && !st.ref_snap[3])
        else $error("missing clock not shown as fast and slow");

    chk_loop_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_LOOP_STATE)
        |=> rd_data == {1'b0, $past(live.loop)})
        else $error("loop status read wrong");

    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && (bus.addr == `DRS_ADDR_RSVD_A || bus.addr == `DRS_ADDR_RSVD_EVENT))
        ##1 1'b1 |-> rd_data == 8'h00)
        else $error("reserved location read non-zero");

    chk_tune_top: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_TUNE_B3)
        |=> rd_data == {2'b00, $past(live.tuning_word[29:24])})
        else $error("tuning word top byte wrong");

    // Per-bit checks of events, snapshot and live readback
    chk_second_validated: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (eff_b[3] && !st.prev_valid[1] && !ev_mask[`DRS_EV_B_VALIDATED])
        |=> st.events[`DRS_EV_B_VALIDATED])
        else $error("second reference validated event lost");

    chk_second_cleared: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!eff_b[2] && st.prev_fault[1] && !ev_mask[`DRS_EV_B_CLEARED])
        |=> st.events[`DRS_EV_B_CLEARED])
        else $error("second reference fault cleared event lost");

    chk_first_fault: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (eff_a[2] && !st.prev_fault[0] && !ev_mask[`DRS_EV_A_FAULT])
        |=> st.events[`DRS_EV_A_FAULT])
        else $error("first reference fault event lost");

    chk_no_spurious: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1
        |=> (st.events & ~$past(st.events) & ~$past(ev_set)) == 8'h00)
        else $error("event bit set without an event");

    chk_reserved_events: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1
        |-> (st.events & 8'h88) == 8'h00)
        else $error("reserved event bit set");

    chk_clear_bit: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ev_clear[`DRS_EV_A_FAULT] && !ev_set[`DRS_EV_A_FAULT])
        |=> !st.events[`DRS_EV_A_FAULT])
        else $error("event clear did not clear");

    chk_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (ev_set != 8'h00)
        |=> (st.events & $past(ev_set)) == $past(ev_set))
        else $error("event lost to a clear in the same cycle");

    chk_first_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_update
        |=> st.ref_snap[3] == ($past(live.first_reference.timer_expired)
            && !$past(live.first_reference.fault) && !$past(live.first_reference.missing)))
        else $error("first reference valid flag wrong");

    chk_second_valid: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_update
        |=> st.ref_snap[7] == ($past(live.second_reference.timer_expired)
            && !$past(live.second_reference.fault) && !$past(live.second_reference.missing)))
        else $error("second reference valid flag wrong");

    chk_first_unusable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (io_update && (live.first_reference.fault || live.first_reference.missing))
        |=> st.ref_snap[2])
        else $error("first reference fault flag missing");

    chk_second_unusable: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (io_update && (live.second_reference.fault || live.second_reference.missing))
        |=> st.ref_snap[6])
        else $error("second reference fault flag missing");

    chk_first_fast: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (io_update && live.first_reference.fast)
        |=> st.ref_snap[1])
        else $error("first reference fast flag missing");

    chk_second_fast: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (io_update && live.second_reference.fast)
        |=> st.ref_snap[5])
        else $error("second reference fast flag missing");

    chk_first_slow: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (io_update && live.first_reference.slow)
        |=> st.ref_snap[0])
        else $error("first reference slow flag missing");

    chk_second_slow: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (io_update && live.second_reference.slow)
        |=> st.ref_snap[4])
        else $error("second reference slow flag missing");

    chk_second_missing: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (io_update && live.second_reference.missing)
        |=> st.ref_snap[5:4] == 2'b11 && st.ref_snap[6] && !st.ref_snap[7])
        else $error("second missing clock not shown as fast and slow");

    chk_snap_update: assert property (@(posedge sys_clk) disable iff (sys_rst)
        io_update
        |=> st.ref_snap == {$past(eff_b), $past(eff_a)})
        else $error("reference status not refreshed on update");

    chk_update_exact: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.wr && bus.addr == `DRS_ADDR_IO_UPDATE && bus.wdata != `DRS_IO_UPDATE_VAL)
        |=> $stable(st.ref_snap))
        else $error("wrong update value refreshed status");

    chk_write_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.wr && bus.addr != `DRS_ADDR_IO_UPDATE)
        |=> $stable(st.ref_snap))
        else $error("write to status location changed state");

    chk_loop_switch: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_LOOP_STATE)
        |=> rd_data[3] == $past(live.loop.switching))
        else $error("switchover bit wrong");

    chk_loop_lock: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_LOOP_STATE)
        |=> rd_data[5:4] == {$past(live.loop.freq_lock), $past(live.loop.phase_lock)})
        else $error("lock bits wrong");

    chk_loop_slew: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_LOOP_STATE)
        |=> rd_data[7:6] == {1'b0, $past(live.loop.slew_limited)})
        else $error("slew limit bit wrong");

    chk_clamp_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_LOOP_REF)
        |=> rd_data[7:5] == {2'b00, $past(live.clamped)})
        else $error("clamp flag wrong");

    chk_history_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_LOOP_REF)
        |=> rd_data[4] == $past(live.history_ready))
        else $error("history flag wrong");

    chk_priority_field: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_LOOP_REF)
        |=> rd_data[3:2] == $past(live.active_priority))
        else $error("active priority wrong");

    chk_active_index: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_LOOP_REF)
        |=> rd_data[1:0] == {1'b0, $past(live.active_index)})
        else $error("active index wrong");

    chk_tune_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_TUNE_B0)
        |=> rd_data == $past(live.tuning_word[7:0]))
        else $error("tuning word low byte wrong");

    chk_tune_second: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_TUNE_B1)
        |=> rd_data == $past(live.tuning_word[15:8]))
        else $error("tuning word second byte wrong");

    chk_tune_third: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_TUNE_B2)
        |=> rd_data == $past(live.tuning_word[23:16]))
        else $error("tuning word third byte wrong");

    chk_phase_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_PHASE_LO)
        |=> rd_data == $past(live.phase_level[7:0]))
        else $error("phase level low byte wrong");

    chk_phase_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_PHASE_HI)
        |=> rd_data == {4'h0, $past(live.phase_level[11:8])})
        else $error("phase level high nibble wrong");

    chk_freq_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_FREQ_LO)
        |=> rd_data == $past(live.freq_level[7:0]))
        else $error("frequency level low byte wrong");

    chk_freq_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_FREQ_HI)
        |=> rd_data == {4'h0, $past(live.freq_level[11:8])})
        else $error("frequency level high nibble wrong");

    chk_read_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !bus.rd
        |=> rd_data == 8'h00)
        else $error("read data not zero outside a read");

    chk_reserved_b: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_RSVD_B)
        |=> rd_data == 8'h00)
        else $error("reserved status location read non-zero");

    chk_event_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_REF_EVENT)
        |=> rd_data == ($past(st.events) & 8'h77))
        else $error("event register read wrong");

    chk_status_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bus.rd && bus.addr == `DRS_ADDR_INPUT_REF)
        |=> rd_data == $past(st.ref_snap))
        else $error("reference status read wrong");

endmodule

// [tb/tb_drs_readback.sv]
// Self-checking bench for the loop and reference status readback
`timescale 1ns/1ps
`include "drs_params.svh"

module tb_drs_readback;
    logic sys_clk;
    logic sys_rst;
    drs_pkg::drs_bus_t bus;
    logic [7:0] rd_data;
    drs_pkg::drs_live_t live;
    logic [7:0] ev_mask;
    logic [7:0] ev_clear;
    logic ev_clear_all;
    int error_cnt;
    int n_compared;

    drs_readback dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .bus(bus),
        .rd_data(rd_data),
        .live(live),
        .ev_mask(ev_mask),
        .ev_clear(ev_clear),
        .ev_clear_all(ev_clear_all)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        bus <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] addr, input logic [7:0] exp);
        @(posedge sys_clk);
        bus <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1;
        chk($sformatf("addr %h", addr), exp, rd_data);
    endtask

    initial
    begin
        #(50 * 3000);
        error_cnt++;
        $display("watchdog expired");
        wrap_up();
    end

    initial
    begin
        sys_rst = 1'b1;
        bus = '0;
        live = '0;
        ev_mask = 8'h00;
        ev_clear = 8'h00;
        ev_clear_all = 1'b0;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // Loop state and loop reference registers, read live
        live.loop <= 7'h55;
        rd(`DRS_ADDR_LOOP_STATE, 8'h55);
        live.loop <= 7'h2A;
        rd(`DRS_ADDR_LOOP_STATE, 8'h2A);
        live.clamped <= 1'b1;
        live.active_priority <= 2'b10;
        live.active_index <= 1'b1;
        rd(`DRS_ADDR_LOOP_REF, 8'h29);
        live.clamped <= 1'b0;
        live.history_ready <= 1'b1;
        live.active_priority <= 2'b01;
        live.active_index <= 1'b0;
        rd(`DRS_ADDR_LOOP_REF, 8'h14);
        $display("test loop status done");
        // Wide values, LSB first; top bits of the word read zero
        live.tuning_word <= 30'h3ABCDEF1;
        live.phase_level <= 12'hA5C;
        live.freq_level <= 12'h3E7;
        rd(`DRS_ADDR_TUNE_B0, 8'hF1);
        rd(`DRS_ADDR_TUNE_B1, 8'hDE);
        rd(`DRS_ADDR_TUNE_B2, 8'hBC);
        rd(`DRS_ADDR_TUNE_B3, 8'h3A);
        rd(`DRS_ADDR_PHASE_LO, 8'h5C);
        rd(`DRS_ADDR_PHASE_HI, 8'h0A);
        wr(`DRS_ADDR_FREQ_LO, 8'hFF);
        rd(`DRS_ADDR_FREQ_LO, 8'hE7);
        rd(`DRS_ADDR_FREQ_HI, 8'h03);
        rd(`DRS_ADDR_RSVD_EVENT, 8'h00);
        rd(`DRS_ADDR_RSVD_A, 8'h00);
        rd(`DRS_ADDR_RSVD_B, 8'h00);
        $display("test readback words done");
        // Snapshot changes only on the exact refresh write
        live.first_reference <= '{timer_expired: 1'b1, default: 1'b0};
        live.second_reference <= '{timer_expired: 1'b1, missing: 1'b1, default: 1'b0};
        rd(`DRS_ADDR_INPUT_REF, 8'h00);
        wr(`DRS_ADDR_IO_UPDATE, 8'h02);
        rd(`DRS_ADDR_INPUT_REF, 8'h00);
        wr(`DRS_ADDR_IO_UPDATE, `DRS_IO_UPDATE_VAL);
        rd(`DRS_ADDR_INPUT_REF, 8'h78);
        live.first_reference.fast <= 1'b1;
        live.second_reference <= '{timer_expired: 1'b1, slow: 1'b1, default: 1'b0};
        wr(`DRS_ADDR_IO_UPDATE, `DRS_IO_UPDATE_VAL);
        rd(`DRS_ADDR_INPUT_REF, 8'h9A);
        $display("test input status done");
        // Sticky events, per-bit clear and masking
        ev_clear_all <= 1'b1;
        @(posedge sys_clk);
        ev_clear_all <= 1'b0;
        rd(`DRS_ADDR_REF_EVENT, 8'h00);
        live.first_reference.fault <= 1'b1;
        rd(`DRS_ADDR_REF_EVENT, 8'h01);
        live.first_reference.fault <= 1'b0;
        rd(`DRS_ADDR_REF_EVENT, 8'h07);
        rd(`DRS_ADDR_REF_EVENT, 8'h07);
        ev_clear <= 8'h01;
        @(posedge sys_clk);
        ev_clear <= 8'h00;
        ev_mask <= 8'h10;
        live.second_reference.fault <= 1'b1;
        rd(`DRS_ADDR_REF_EVENT, 8'h06);
        live.second_reference.fault <= 1'b0;
        rd(`DRS_ADDR_REF_EVENT, 8'h66);
        ev_mask <= 8'h00;
        live.second_reference.missing <= 1'b1;
        rd(`DRS_ADDR_REF_EVENT, 8'h76);
        $display("test events done");
        wrap_up();
    end
endmodule
